// [design/sdram_timing_regs.vh]
// register offsets, field positions and defaults of the sdram timing block
`ifndef SDRAM_TIMING_REGS_VH
`define SDRAM_TIMING_REGS_VH
`define ADDR_W 24
`define DRAM_CONTROL_ADDR 24'hFFFDA2
`define SDRAM_CONTROL_ADDR 24'hFFFDA4
`define DRAM_CONTROL_RST 16'h0000
`define SDRAM_CONTROL_RST 16'h0000
`define SDRAM_CONTROL_MASK 16'h8080
`define DRAM_CONTROL_MASK 16'hF300
`define BIT_DRAM_IF_SEL 15
`define BIT_DRAM_TYPE 14
`define BIT_PRECHARGE_HI 13
`define BIT_PRECHARGE_LO 12
`define BIT_RAS_CAS_HI 9
`define BIT_RAS_CAS_LO 8
`define BIT_MODE_SET_EN 15
`define BIT_CLK_SUSPEND 7
`define CNT_W 4
`define TPC_CODE1 4'h2
`define TPC_CODE2 4'h3
`define TPC_CODE3 4'h4
`define RCD_CODE1 4'h1
`define RCD_CODE2 4'h2
`define RCD_CODE3 4'h3
`endif

// [design/cycle_counter.v]
// loadable down counter used for precharge and ras-to-cas waits
`timescale 1ns/10ps
module cycle_counter #(
	parameter W = 4
) (
	// clock and reset
	input wire ref_clk,
	input wire sys_rst,
	// control
	input wire load,
	input wire [W-1:0] value,
	// status
	output wire busy
);
	reg [W-1:0] count;
	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			count <= {W{1'b0}};
		else if (load)
			count <= value;
		else if (count != {W{1'b0}})
			count <= count - {{(W-1){1'b0}}, 1'b1};
	end
	assign busy = (count != {W{1'b0}});
endmodule

// [design/sdram_timing_mode_control.v]
// sdram access sequencer with precharge, ras-cas, mode set and suspend
`timescale 1ns/10ps
`include "sdram_timing_regs.vh"
// Overview of operation
// - precharge field sets precharge cycles, normal and refresh; 00 is one
// - ras-cas field picks wait cycles between ras and cas; 00 is none
// - mode register set only runs while mode_set_enable is 1
// - clock_suspend_enable holds each read data output one extra cycle
// - sdram controls act only with sdram interface and sdram type selected
module sdram_timing_mode_control #(
	parameter CW = `CNT_W,
	parameter [CW-1:0] PRECHARGE_COUNT_HI = `TPC_CODE1,
	parameter [CW-1:0] TPC2 = `TPC_CODE2,
	parameter [CW-1:0] TPC3 = `TPC_CODE3,
	parameter [CW-1:0] RAS_CAS_WAIT_HI = `RCD_CODE1,
	parameter [CW-1:0] RCD2 = `RCD_CODE2,
	parameter [CW-1:0] RCD3 = `RCD_CODE3
) (
	// clock and reset
	input wire ref_clk,
	input wire sys_rst,
	// register port
	input wire [`ADDR_W-1:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [15:0] reg_rdata,
	// access requests
	input wire acc_req,
	input wire acc_refresh,
	input wire acc_mode_set,
	output wire acc_ready,
	output reg acc_done,
	output reg mode_set_blocked,
	// sdram command phases
	output reg ras_phase,
	output reg cas_phase,
	output reg precharge_phase,
	output reg refresh_phase,
	output reg mode_set_phase,
	// read data path
	input wire [15:0] mem_rdata,
	input wire mem_rvalid,
	output reg [15:0] rd_data,
	output reg rd_valid,
	// sdram mode active
	output wire sdram_active
);
	localparam S_IDLE = 6'b000001;
	localparam S_RAS = 6'b000010;
	localparam S_WAIT = 6'b000100;
	localparam S_CAS = 6'b001000;
	localparam S_PRE = 6'b010000;
	localparam S_MRS = 6'b100000;

	reg [15:0] dram_control;
	reg [15:0] sdram_control;
	reg [5:0] state;
	reg [5:0] next_state;
	reg pending_refresh;
	reg next_pending_refresh;
	reg hold_pending;
	reg [15:0] hold_data;
	reg pre_load;
	reg rcd_load;
	wire pre_busy;
	wire rcd_busy;
	reg [CW-1:0] pre_count;
	reg [CW-1:0] rcd_count;
	wire [CW-1:0] pre_init;
	wire [CW-1:0] rcd_init;
	wire [1:0] pre_code;
	wire [1:0] rcd_code;
	wire mode_set_en;
	wire suspend_en;
	wire hit_dram;
	wire hit_sdram;
	wire mode_set_ok;
	wire mode_set_refused;
	reg next_acc_done;
	reg next_mode_set_blocked;
	reg next_refresh_phase;

	assign pre_code = {dram_control[`BIT_PRECHARGE_HI],
		dram_control[`BIT_PRECHARGE_LO]};
	assign rcd_code = {dram_control[`BIT_RAS_CAS_HI],
		dram_control[`BIT_RAS_CAS_LO]};
	assign sdram_active = dram_control[`BIT_DRAM_IF_SEL] &
		dram_control[`BIT_DRAM_TYPE];
	assign mode_set_en = sdram_active &
		sdram_control[`BIT_MODE_SET_EN];
	assign suspend_en = sdram_active &
		sdram_control[`BIT_CLK_SUSPEND];

	// address decode of the two control registers
	assign hit_dram = (reg_addr == `DRAM_CONTROL_ADDR);
	assign hit_sdram = (reg_addr == `SDRAM_CONTROL_ADDR);
	// a mode set request is run or refused at once, never held over
	assign mode_set_ok = acc_req && acc_mode_set && mode_set_en;
	assign mode_set_refused = acc_req && acc_mode_set && !mode_set_en;

	// register writes; only implemented bits are kept
	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dram_control <= `DRAM_CONTROL_RST;
		end else if (reg_wr && hit_dram) begin
			dram_control <= reg_wdata & `DRAM_CONTROL_MASK;
		end
	end

	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sdram_control <= `SDRAM_CONTROL_RST;
		end else if (reg_wr && hit_sdram) begin
			sdram_control <= reg_wdata & `SDRAM_CONTROL_MASK;
		end
	end

	// read data one cycle after the strobe, else zero
	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd && hit_dram) begin
			reg_rdata <= dram_control;
		end else if (reg_rd && hit_sdram) begin
			reg_rdata <= sdram_control;
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	// code to cycle count; code 00 still gives one precharge cycle
	always @* begin
		case (pre_code)
		2'b00: pre_count = {{(CW-1){1'b0}}, 1'b1};
		2'b01: pre_count = PRECHARGE_COUNT_HI;
		2'b10: pre_count = TPC2;
		default: pre_count = TPC3;
		endcase
	end

	// code 00 skips the wait state altogether
	always @* begin
		case (rcd_code)
		2'b00: rcd_count = {CW{1'b0}};
		2'b01: rcd_count = RAS_CAS_WAIT_HI;
		2'b10: rcd_count = RCD2;
		default: rcd_count = RCD3;
		endcase
	end

	// counters start one below the length, the first cycle being the load;
	// a zero precharge count parameter is therefore not supported
	assign pre_init = pre_count - {{(CW-1){1'b0}}, 1'b1};
	assign rcd_init = rcd_count - {{(CW-1){1'b0}}, 1'b1};

	cycle_counter #(.W(CW)) u_pre (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.load(pre_load),
		.value(pre_init),
		.busy(pre_busy)
	);

	cycle_counter #(.W(CW)) u_rcd (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.load(rcd_load),
		.value(rcd_init),
		.busy(rcd_busy)
	);

	assign acc_ready = (state == S_IDLE);

	// access sequencer
	always @* begin
		next_state = state;
		pre_load = 1'b0;
		rcd_load = 1'b0;
		case (state)
		S_IDLE: begin
			if (mode_set_ok) begin
				next_state = S_MRS;
			end else if (acc_req && !acc_mode_set) begin
				next_state = S_RAS;
			end
		end
		S_RAS: begin
			if (pending_refresh) begin
				// refresh closes the row with no column phase
				next_state = S_PRE;
				pre_load = 1'b1;
			end else if (rcd_count == {CW{1'b0}}) begin
				next_state = S_CAS;
			end else begin
				next_state = S_WAIT;
				rcd_load = 1'b1;
			end
		end
		S_WAIT: begin
			if (!rcd_busy) begin
				next_state = S_CAS;
			end
		end
		S_CAS: begin
			next_state = S_PRE;
			pre_load = 1'b1;
		end
		S_PRE: begin
			if (!pre_busy) begin
				next_state = S_IDLE;
			end
		end
		S_MRS: begin
			next_state = S_PRE;
			pre_load = 1'b1;
		end
		default: begin
			next_state = S_IDLE;
		end
		endcase
	end

	// status flags and refresh tracking, registered below
	always @* begin
		next_pending_refresh = pending_refresh;
		next_acc_done = 1'b0;
		next_mode_set_blocked = 1'b0;
		next_refresh_phase = 1'b0;
		if (state == S_IDLE) begin
			if (acc_req) begin
				next_pending_refresh = acc_refresh & ~acc_mode_set;
			end
			next_mode_set_blocked = mode_set_refused;
			next_refresh_phase = acc_req && !acc_mode_set && acc_refresh;
		end
		if (state == S_PRE && next_state == S_IDLE) begin
			next_acc_done = 1'b1;
		end
	end

	// state register
	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= S_IDLE;
			pending_refresh <= 1'b0;
		end else begin
			state <= next_state;
			pending_refresh <= next_pending_refresh;
		end
	end

	// status pulses come from flip-flops
	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			acc_done <= 1'b0;
			mode_set_blocked <= 1'b0;
			refresh_phase <= 1'b0;
		end else begin
			acc_done <= next_acc_done;
			mode_set_blocked <= next_mode_set_blocked;
			refresh_phase <= next_refresh_phase;
		end
	end

	// phase outputs line up with the state they stand for
	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ras_phase <= 1'b0;
			cas_phase <= 1'b0;
			precharge_phase <= 1'b0;
			mode_set_phase <= 1'b0;
		end else begin
			ras_phase <= (next_state == S_RAS);
			cas_phase <= (next_state == S_CAS);
			precharge_phase <= (next_state == S_PRE);
			mode_set_phase <= (next_state == S_MRS);
		end
	end

	// suspension repeats each read word for one more cycle; a new word
	// wins over the repeat, though the memory never sends two in a row
	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			hold_pending <= 1'b0;
			hold_data <= 16'h0000;
		end else if (mem_rvalid) begin
			hold_pending <= suspend_en;
			hold_data <= mem_rdata;
		end else begin
			hold_pending <= 1'b0;
		end
	end

	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_data <= 16'h0000;
			rd_valid <= 1'b0;
		end else if (mem_rvalid) begin
			rd_data <= mem_rdata;
			rd_valid <= 1'b1;
		end else if (hold_pending) begin
			rd_data <= hold_data;
			rd_valid <= 1'b1;
		end else begin
			rd_valid <= 1'b0;
		end
	end
endmodule

// [dv/sdram_timing_props.sv]
// port checker for the sdram timing block
`timescale 1ns/10ps
module sdram_timing_props (
	// clock and reset
	input wire ref_clk,
	input wire sys_rst,
	// access side
	input wire acc_ready,
	input wire acc_done,
	input wire mode_set_blocked,
	input wire sdram_active,
	// phases and read path
	input wire ras_phase,
	input wire cas_phase,
	input wire precharge_phase,
	input wire refresh_phase,
	input wire mode_set_phase,
	input wire mem_rvalid,
	input wire rd_valid
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	sequence ms_then_pre;
		mode_set_phase ##1 precharge_phase;
	endsequence
	sequence ras_no_cas;
		ras_phase ##1 (precharge_phase && !cas_phase);
	endsequence
	sequence cas_soon;
		##[1:4] cas_phase;
	endsequence
	a_blocked_quiet: assert property (
		mode_set_blocked |-> acc_ready && !mode_set_phase)
		else $error("mode set ran while refused");
	a_mode_needs_sdram: assert property (
		mode_set_phase |-> sdram_active)
		else $error("mode set outside sdram mode");
	a_mode_then_pre: assert property (
		$rose(mode_set_phase) |-> ms_then_pre)
		else $error("mode set not closed by precharge");
	a_refresh_no_cas: assert property (
		refresh_phase |-> ras_no_cas)
		else $error("refresh access showed a column phase");
	a_ras_then_cas: assert property (
		ras_phase && !refresh_phase |-> cas_soon)
		else $error("column phase late after row phase");
	a_pre_bounded: assert property (
		$rose(precharge_phase) |-> ##[1:4] !precharge_phase)
		else $error("precharge longer than four cycles");
	a_done_after_pre: assert property (
		acc_done |-> $past(precharge_phase))
		else $error("done without precharge before it");
	a_read_follows: assert property (
		mem_rvalid |=> rd_valid)
		else $error("read word not passed on");
	a_read_extra: assert property (
		$rose(rd_valid) |-> ##[1:2] !rd_valid)
		else $error("read word held too long");
	a_busy_phases: assert property (
		ras_phase || cas_phase || precharge_phase || mode_set_phase
		|-> !acc_ready)
		else $error("ready during an access");
endmodule
bind sdram_timing_mode_control sdram_timing_props u_props (.ref_clk, .sys_rst,
	.acc_ready, .acc_done, .mode_set_blocked, .sdram_active, .ras_phase,
	.cas_phase, .precharge_phase, .refresh_phase, .mode_set_phase,
	.mem_rvalid, .rd_valid);

// [dv/sdram_far_model.sv]
// far-side sdram model answering each column phase with one read word
`timescale 1ns/10ps
module sdram_far_model (
	// clock and reset
	input wire ref_clk,
	input wire sys_rst,
	// command and read data
	input wire cas_phase,
	output reg [15:0] mem_rdata,
	output reg mem_rvalid
);
	// an idle bus keeps changing so a stale word is never mistaken for data
	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mem_rdata <= 16'h0000;
			mem_rvalid <= 1'b0;
		end else begin
			mem_rvalid <= cas_phase;
			mem_rdata <= cas_phase ? 16'hA5C3 : ~mem_rdata;
		end
	end
endmodule

// [dv/sdram_timing_mode_control_tb.sv]
// self-checking bench for the sdram timing block
`timescale 1ns/10ps
`include "sdram_timing_regs.vh"
module sdram_timing_mode_control_tb;
	reg ref_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
	reg acc_req = 0, acc_refresh = 0, acc_mode_set = 0;
	reg [23:0] reg_addr = 24'h000000;
	reg [15:0] reg_wdata = 16'h0000;
	wire [15:0] reg_rdata, mem_rdata, rd_data;
	wire acc_ready, acc_done, mode_set_blocked, ras_phase, cas_phase;
	wire precharge_phase, refresh_phase, mode_set_phase, mem_rvalid;
	wire rd_valid, sdram_active;
	integer n_mismatch = 0, check_count = 0, cyc = 0, i, j, lp, lw;
	integer n_pre, n_wait, n_cas, n_ras, n_ms, n_blk, n_rd, n_rf, n_dn;
	sdram_timing_mode_control dut (.ref_clk, .sys_rst, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .acc_req, .acc_refresh, .acc_mode_set,
		.acc_ready, .acc_done, .mode_set_blocked, .ras_phase, .cas_phase,
		.precharge_phase, .refresh_phase, .mode_set_phase, .mem_rdata,
		.mem_rvalid, .rd_data, .rd_valid, .sdram_active);
	sdram_far_model far (.ref_clk, .sys_rst, .cas_phase, .mem_rdata,
		.mem_rvalid);
	initial forever #25 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc = cyc + 1;
		if (cyc == 2000) begin
			n_mismatch = n_mismatch + 1;
			tally_and_finish;
		end
	end
	task chk(input [15:0] got, input [15:0] exp);
		begin
			check_count = check_count + 1;
			if (got !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task wr(input [23:0] a, input [15:0] d);
		begin
			@(posedge ref_clk);
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
			@(posedge ref_clk);
			reg_wr <= 1'b0;
		end
	endtask
	task rd(input [23:0] a, input [15:0] e);
		begin
			@(posedge ref_clk);
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge ref_clk);
			reg_rd <= 1'b0;
			@(negedge ref_clk);
			chk(reg_rdata, e);
		end
	endtask
	// phase widths are counted over a window longer than the slowest access
	task acc(input rf, input ms);
		begin
			@(posedge ref_clk);
			acc_req <= 1'b1;
			acc_refresh <= rf;
			acc_mode_set <= ms;
			@(posedge ref_clk);
			acc_req <= 1'b0;
			{n_pre, n_wait, n_cas, n_ras, n_ms, n_blk, n_rd, n_rf, n_dn} = 0;
			for (j = 0; j < 20; j = j + 1) begin
				@(negedge ref_clk);
				if (n_ras > 0 && n_cas == 0 && n_pre == 0
					&& !ras_phase && !cas_phase && !precharge_phase)
					n_wait = n_wait + 1;
				n_pre = n_pre + precharge_phase;
				n_cas = n_cas + cas_phase;
				n_ras = n_ras + ras_phase;
				n_ms = n_ms + mode_set_phase;
				n_blk = n_blk + mode_set_blocked;
				n_rd = n_rd + rd_valid;
				n_rf = n_rf + refresh_phase;
				n_dn = n_dn + acc_done;
				if (rd_valid)
					chk(rd_data, 16'hA5C3);
			end
		end
	endtask
	task tally_and_finish;
		begin
			if (n_mismatch == 0 && check_count > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	initial begin
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rd(`SDRAM_CONTROL_ADDR, `SDRAM_CONTROL_RST);
		rd(`DRAM_CONTROL_ADDR, `DRAM_CONTROL_RST);
		rd(24'hFFFDA6, 16'h0000);
		wr(`SDRAM_CONTROL_ADDR, 16'hFFFF);
		acc(0, 1);
		chk(n_blk[15:0], 16'h0001);
		wr(`DRAM_CONTROL_ADDR, 16'hC000);
		rd(`SDRAM_CONTROL_ADDR, 16'h8080);
		chk(sdram_active, 1'b1);
		acc(0, 1);
		chk({n_ms[7:0], n_blk[7:0]}, 16'h0100);
		acc(0, 0);
		chk(n_rd[15:0], 16'h0002);
		chk({n_rf[7:0], n_dn[7:0]}, 16'h0001);
		wr(`SDRAM_CONTROL_ADDR, 16'h0000);
		acc(0, 1);
		chk({n_ms[7:0], n_blk[7:0]}, 16'h0001);
		for (i = 0; i < 4; i = i + 1) begin
			wr(`DRAM_CONTROL_ADDR, {2'b11, i[1:0], 2'b11, i[1:0], 8'hFF});
			acc(0, 0);
			chk(n_rd[15:0], 16'h0001);
			if (i == 0) begin
				chk(n_pre[15:0], 16'h0001);
				chk(n_wait[15:0], 16'h0000);
			end else begin
				chk(n_pre > lp, 1'b1);
				chk(n_wait > lw, 1'b1);
			end
			if (i == 3) begin
				chk(n_pre[15:0], {12'h000, `TPC_CODE3});
				chk(n_wait[15:0], {12'h000, `RCD_CODE3});
			end
			lp = n_pre;
			lw = n_wait;
		end
		rd(`DRAM_CONTROL_ADDR, 16'hF300);
		acc(1, 0);
		chk({n_cas[7:0], n_pre[7:0]}, {8'h00, lp[7:0]});
		chk({n_rf[7:0], n_dn[7:0]}, 16'h0101);
		tally_and_finish;
	end
endmodule
